// File: fprc_top.v
// Chosen here: the address map and the APB interface to the registers.
`include "fprc_map.vh"

module fprc_top (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // supply pin level comparators (asynchronous)
   input wire high_key_pulse_level,
   input wire mid_address_pulse_level,
   input wire power_good,
   // fuse array sense and margin comparators
   input wire [13:0] fuse_sense,
   input wire fuse_weak_blown,
   input wire fuse_weak_intact,
   // hall comparator
   input wire hall_trip,
   // fuse blow driver
   output reg blow_strobe,
   output reg [3:0] blow_index,
   // supply current step for marginal fuse
   output reg supply_current_step,
   // trial operate point to analog trim
   output reg trial_active,
   output reg [7:0] trial_magnitude,
   output reg trial_field_sign,
   // sensor output pin, open drain
   output wire sensor_output_pin_o,
   output reg sensor_output_pin_oe
);

   // ----------------------------------------
   // states and modes
   // ----------------------------------------
   localparam S_IDLE = 3'h0; // waiting for key
   localparam S_HKEY = 3'h1; // counting first high group
   localparam S_MKEY = 3'h2; // counting register select
   localparam S_ACT = 3'h3; // key accepted, addressing
   localparam S_DEAD = 3'h4; // key refused until power-off
   localparam M_NONE = 2'h0;
   localparam M_TRIAL = 2'h1;
   localparam M_BLOW = 2'h2;
   localparam M_READ = 2'h3;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // fuse image index of address within register
   function [3:0] fuse_idx;
      input [2:0] sel;
      input [2:0] a;
      begin
         case (sel)
            `FPRC_BR_SIGN: fuse_idx = `FPRC_SIGN_BIT;
            `FPRC_BR_OUTLK: fuse_idx = `FPRC_OL_LSB + {1'b0, a};
            default: fuse_idx = `FPRC_MAG_LSB + {1'b0, a};
         endcase
      end
   endfunction

   // highest address of a blow/read register
   function [2:0] top_addr;
      input [2:0] sel;
      begin
         case (sel)
            `FPRC_BR_SIGN: top_addr = 3'h0;
            `FPRC_BR_OUTLK: top_addr = 3'h4;
            default: top_addr = 3'h7;
         endcase
      end
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg hi_s1_reg, hi_s2_reg, hi_d_reg; // high level sync
   reg mid_s1_reg, mid_s2_reg, mid_d_reg; // mid level sync
   reg pg_s1_reg, pg_s2_reg; // power good sync
   reg wb_s1_reg, wb_s2_reg; // weak blown sync
   reg wi_s1_reg, wi_s2_reg; // weak intact sync
   reg ht_s1_reg, ht_s2_reg; // hall sync
   reg [13:0] fs_s1_reg, fs_s2_reg; // fuse sense sync
   reg loaded_reg; // fuse image captured
   reg [13:0] fuse_reg; // fuse image
   reg [2:0] state_reg;
   reg [1:0] mode_reg;
   reg [2:0] sel_reg; // selected register
   reg [1:0] hcnt_reg; // high pulses in key
   reg [2:0] mcnt_reg; // mid pulses in key
   reg [7:0] code_reg; // trial code
   reg [2:0] addr_reg; // blow/read bit address
   reg [1:0] ctrl_reg; // software control
   reg refused_reg; // last key refused, sticky
   reg [7:0] blows_reg; // blow counter
   wire hfall, mfall, prog_en, locked, abort;
   wire [3:0] cur_idx;
   wire hall_out;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // all comparator outputs are asynchronous to sys_clk
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hi_s1_reg <= 1'b0;
         hi_s2_reg <= 1'b0;
         hi_d_reg <= 1'b0;
         mid_s1_reg <= 1'b0;
         mid_s2_reg <= 1'b0;
         mid_d_reg <= 1'b0;
         pg_s1_reg <= 1'b0;
         pg_s2_reg <= 1'b0;
         wb_s1_reg <= 1'b0;
         wb_s2_reg <= 1'b0;
         wi_s1_reg <= 1'b0;
         wi_s2_reg <= 1'b0;
         ht_s1_reg <= 1'b0;
         ht_s2_reg <= 1'b0;
         fs_s1_reg <= 14'h0000;
         fs_s2_reg <= 14'h0000;
      end else begin
         hi_s1_reg <= high_key_pulse_level;
         hi_s2_reg <= hi_s1_reg;
         hi_d_reg <= hi_s2_reg;
         mid_s1_reg <= mid_address_pulse_level;
         mid_s2_reg <= mid_s1_reg;
         mid_d_reg <= mid_s2_reg;
         pg_s1_reg <= power_good;
         pg_s2_reg <= pg_s1_reg;
         wb_s1_reg <= fuse_weak_blown;
         wb_s2_reg <= wb_s1_reg;
         wi_s1_reg <= fuse_weak_intact;
         wi_s2_reg <= wi_s1_reg;
         ht_s1_reg <= hall_trip;
         ht_s2_reg <= ht_s1_reg;
         fs_s1_reg <= fuse_sense;
         fs_s2_reg <= fs_s1_reg;
      end
   end

   // pulse ends: a high pulse passes the mid level, so a mid
   // pulse counts only when the high level was not reached
   assign hfall = hi_d_reg & ~hi_s2_reg;
   assign mfall = mid_d_reg & ~mid_s2_reg & ~hi_d_reg;
   assign prog_en = ctrl_reg[`FPRC_CTRL_EN_BIT];
   assign abort = ctrl_reg[`FPRC_CTRL_ABORT_BIT];
   assign locked = fuse_reg[`FPRC_LOCK_BIT];
   assign cur_idx = fuse_idx(sel_reg, addr_reg);

   // ----------------------------------------
   // fuse image
   // ----------------------------------------
   // captured once power is seen after reset; the sense sync has
   // filled by then, so reset zeros never land in the image
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         loaded_reg <= 1'b0;
         fuse_reg <= 14'h0000;
      end else if (!loaded_reg && pg_s2_reg) begin
         loaded_reg <= 1'b1;
         fuse_reg <= fs_s2_reg;
      end else if (blow_strobe) begin
         fuse_reg[blow_index] <= 1'b1;
      end
   end

   // ----------------------------------------
   // key decoder and address sequencer
   // ----------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= S_IDLE;
         mode_reg <= M_NONE;
         sel_reg <= 3'h0;
         hcnt_reg <= 2'h0;
         mcnt_reg <= 3'h0;
         code_reg <= 8'h00;
         addr_reg <= 3'h0;
         refused_reg <= 1'b0;
         blow_strobe <= 1'b0;
         blow_index <= 4'h0;
         blows_reg <= 8'h00;
      end else begin
         blow_strobe <= 1'b0;
         if (!pg_s2_reg || !prog_en || abort || !loaded_reg) begin
            // power removed ends any session
            state_reg <= S_IDLE;
            mode_reg <= M_NONE;
            hcnt_reg <= 2'h0;
            mcnt_reg <= 3'h0;
         end else begin
            case (state_reg)
               S_IDLE: begin
                  if (hfall) begin
                     hcnt_reg <= 2'h1;
                     mcnt_reg <= 3'h0;
                     state_reg <= S_HKEY;
                  end
               end
               S_HKEY: begin
                  if (hfall) begin
                     // more than three highs is no key
                     if (hcnt_reg == 2'h3)
                        state_reg <= S_DEAD;
                     else
                        hcnt_reg <= hcnt_reg + 2'h1;
                  end else if (mfall) begin
                     mcnt_reg <= 3'h1;
                     state_reg <= S_MKEY;
                  end
               end
               S_MKEY: begin
                  if (mfall) begin
                     if (mcnt_reg == 3'h5)
                        state_reg <= S_DEAD;
                     else
                        mcnt_reg <= mcnt_reg + 3'h1;
                  end else if (hfall) begin
                     // last high of the key has fallen
                     sel_reg <= mcnt_reg - 3'h1;
                     addr_reg <= 3'h0;
                     code_reg <= `FPRC_CODE_FIRST;
                     state_reg <= S_ACT;
                     refused_reg <= 1'b0;
                     case (hcnt_reg)
                        `FPRC_HK_TRIAL: begin
                           // check register stays open
                           if (mcnt_reg - 3'h1 > `FPRC_TR_CHECK
                               || (locked && mcnt_reg - 3'h1
                                   != `FPRC_TR_CHECK)) begin
                              state_reg <= S_DEAD;
                              refused_reg <= 1'b1;
                           end else
                              mode_reg <= M_TRIAL;
                        end
                        `FPRC_HK_BLOW: begin
                           if (locked
                               || mcnt_reg - 3'h1 > `FPRC_BR_OUTLK) begin
                              state_reg <= S_DEAD;
                              refused_reg <= 1'b1;
                           end else
                              mode_reg <= M_BLOW;
                        end
                        `FPRC_HK_READ: begin
                           // same selects as blow
                           if (locked
                               || mcnt_reg - 3'h1 > `FPRC_BR_OUTLK) begin
                              state_reg <= S_DEAD;
                              refused_reg <= 1'b1;
                           end else
                              mode_reg <= M_READ;
                        end
                        default: begin
                           state_reg <= S_DEAD;
                           refused_reg <= 1'b1;
                        end
                     endcase
                  end
               end
               S_ACT: begin
                  if (mfall) begin
                     if (mode_reg == M_TRIAL)
                        code_reg <= code_reg + 8'h01;
                     else if (addr_reg != top_addr(sel_reg))
                        addr_reg <= addr_reg + 3'h1;
                  end else if (hfall && mode_reg == M_BLOW
                               && !locked) begin
                     // one bit per blow pulse
                     blow_strobe <= 1'b1;
                     blow_index <= cur_idx;
                     blows_reg <= blows_reg + 8'h01;
                  end
                  // a high pulse in read mode never blows
               end
               S_DEAD: begin
                  mode_reg <= M_NONE; // wait for power-off
               end
               default: state_reg <= S_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // trial operate point and fuse check
   // ----------------------------------------
   // trial values drive the trim only while the mode lasts,
   // fuses fall back in as soon as the session ends
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trial_active <= 1'b0;
         trial_magnitude <= 8'h00;
         trial_field_sign <= 1'b0;
         supply_current_step <= 1'b0;
      end else begin
         trial_active <= 1'b0;
         supply_current_step <= 1'b0;
         trial_magnitude <= fuse_reg[`FPRC_MAG_MSB:`FPRC_MAG_LSB];
         trial_field_sign <= fuse_reg[`FPRC_SIGN_BIT];
         if (state_reg == S_ACT && mode_reg == M_TRIAL) begin
            case (sel_reg)
               `FPRC_TR_POS_UP, `FPRC_TR_NEG_UP: begin
                  trial_active <= 1'b1;
                  trial_magnitude <= code_reg;
                  trial_field_sign <= sel_reg[1];
               end
               `FPRC_TR_POS_DN, `FPRC_TR_NEG_DN: begin
                  trial_active <= 1'b1;
                  // inverted code
                  trial_magnitude <= `FPRC_MAG_MAX - code_reg;
                  trial_field_sign <= sel_reg[1];
               end
               default: begin
                  // check register, only reached in trial
                  if (code_reg == `FPRC_CHK_LOW)
                     supply_current_step <= wi_s2_reg;
                  else if (code_reg == `FPRC_CHK_HIGH)
                     supply_current_step <= wb_s2_reg;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // sensor output pin
   // ----------------------------------------
   // normal output follows hall and polarity fuse
   assign hall_out = ht_s2_reg ^ fuse_reg[`FPRC_OUT_SENSE_BIT];
   assign sensor_output_pin_o = 1'b0;

   // open drain: enable means pull low
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sensor_output_pin_oe <= 1'b0;
      end else if (state_reg == S_ACT && mode_reg == M_READ) begin
         // raw fuse, polarity ignored
         sensor_output_pin_oe <= ~fuse_reg[cur_idx];
      end else begin
         sensor_output_pin_oe <= ~hall_out;
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // zero wait states; errors only for unmapped addresses
   assign pready = 1'b1;
   assign pslverr = psel && penable
                    && paddr != `FPRC_CTRL_OFF
                    && paddr != `FPRC_STAT_OFF
                    && paddr != `FPRC_FUSE_OFF
                    && paddr != `FPRC_TRIM_OFF;

   // control write, only control is writable
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `FPRC_CTRL_RST;
      end else if (psel && penable && pwrite
                   && paddr == `FPRC_CTRL_OFF) begin
         ctrl_reg <= pwdata[1:0];
      end
   end

   // read data registered in setup so it stands in access
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `FPRC_CTRL_OFF: prdata <= {30'h0, ctrl_reg};
            `FPRC_STAT_OFF: prdata <= {4'h0, blows_reg,
                                       3'h0, locked,
                                       1'b0, addr_reg,
                                       refused_reg, sel_reg,
                                       1'b0, state_reg,
                                       2'h0, mode_reg};
            `FPRC_FUSE_OFF: prdata <= {18'h0, fuse_reg};
            `FPRC_TRIM_OFF: prdata <= {13'h0, supply_current_step,
                                       trial_active,
                                       trial_field_sign,
                                       trial_magnitude,
                                       code_reg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule

// File: fprc_map.vh
`ifndef FPRC_MAP_VH
`define FPRC_MAP_VH
// apb register offsets
`define FPRC_CTRL_OFF 8'h00
`define FPRC_STAT_OFF 8'h04
`define FPRC_FUSE_OFF 8'h08
`define FPRC_TRIM_OFF 8'h0C
// control fields
`define FPRC_CTRL_EN_BIT 0
`define FPRC_CTRL_ABORT_BIT 1
`define FPRC_CTRL_RST 2'h1
// key first-group high pulse counts
`define FPRC_HK_TRIAL 2'h1
`define FPRC_HK_BLOW 2'h2
`define FPRC_HK_READ 2'h3
// trial register selects (mid pulse count minus one)
`define FPRC_TR_POS_UP 3'h0
`define FPRC_TR_POS_DN 3'h1
`define FPRC_TR_NEG_UP 3'h2
`define FPRC_TR_NEG_DN 3'h3
`define FPRC_TR_CHECK 3'h4
// blow / read register selects
`define FPRC_BR_MAG 3'h0
`define FPRC_BR_SIGN 3'h1
`define FPRC_BR_OUTLK 3'h2
// fuse image layout
`define FPRC_FUSE_W 14
`define FPRC_MAG_LSB 4'h0
`define FPRC_MAG_MSB 4'h7
`define FPRC_SIGN_BIT 4'h8
`define FPRC_OL_LSB 4'h9
`define FPRC_OL_MSB 4'hD
`define FPRC_OUT_SENSE_BIT 4'hB
`define FPRC_LOCK_BIT 4'hD
// check codes and trial code values
`define FPRC_CHK_LOW 8'h08
`define FPRC_CHK_HIGH 8'h09
`define FPRC_CODE_FIRST 8'h01
`define FPRC_MAG_MAX 8'hFF
`endif

// File: fprc_top_props.sv
module fprc_props (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // supply and sense levels
   input wire high_key_pulse_level,
   input wire mid_address_pulse_level,
   input wire power_good,
   input wire [13:0] fuse_sense,
   input wire fuse_weak_blown,
   input wire fuse_weak_intact,
   input wire hall_trip,
   // design outputs
   input wire blow_strobe,
   input wire [3:0] blow_index,
   input wire supply_current_step,
   input wire trial_active,
   input wire [7:0] trial_magnitude,
   input wire sensor_output_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ------
   // quiet-time counters
   // ------
   // saturating, so a long quiet spell never wraps back to zero
   logic [3:0] hk_reg, md_reg, wk_reg, pg_reg, hl_reg;
   function automatic logic [3:0] sat(input logic [3:0] c);
      sat = (c == 4'hF) ? c : c + 4'h1;
   endfunction
   // count cycles since each level was last high, hall since it last changed
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hk_reg <= 4'h0;
         md_reg <= 4'h0;
         wk_reg <= 4'h0;
         pg_reg <= 4'h0;
         hl_reg <= 4'h0;
      end else begin
         hk_reg <= high_key_pulse_level ? 4'h0 : sat(hk_reg);
         md_reg <= mid_address_pulse_level ? 4'h0 : sat(md_reg);
         wk_reg <= (fuse_weak_blown | fuse_weak_intact) ? 4'h0 : sat(wk_reg);
         pg_reg <= power_good ? 4'h0 : sat(pg_reg);
         hl_reg <= $changed(hall_trip) ? 4'h0 : sat(hl_reg);
      end
   end
   // ------
   // properties
   // ------
   property p_one; blow_strobe |=> !blow_strobe; endproperty
   a_one: assert property (p_one) else $error("strobe too long");
   property p_idx; blow_strobe |-> blow_index <= 4'hD; endproperty
   a_idx: assert property (p_idx) else $error("blow index out of image");
   property p_late; blow_strobe |-> hk_reg >= 4'h1 && hk_reg <= 4'hA;
   endproperty
   a_late: assert property (p_late) else $error("blow without pulse");
   property p_lock; blow_strobe |-> !fuse_sense[13]; endproperty
   a_lock: assert property (p_lock) else $error("blow while locked");
   property p_lkout; fuse_sense[13] && hl_reg >= 4'h6 |->
      sensor_output_pin_oe == !(hall_trip ^ fuse_sense[11]); endproperty
   a_lkout: assert property (p_lkout) else $error("read while locked");
   property p_weak; wk_reg >= 4'h6 |-> !supply_current_step; endproperty
   a_weak: assert property (p_weak) else $error("step without fault");
   property p_hold; trial_active && power_good && md_reg >= 4'h8 |=>
      $stable(trial_magnitude); endproperty
   a_hold: assert property (p_hold) else $error("trim moved alone");
   property p_pgoff; pg_reg >= 4'h6 |-> !trial_active; endproperty
   a_pgoff: assert property (p_pgoff) else $error("trial kept unpowered");
   property p_ntr; blow_strobe |-> !trial_active; endproperty
   a_ntr: assert property (p_ntr) else $error("blow during trial");
   c_blow: cover property (blow_strobe);
   c_step: cover property (supply_current_step);
   c_trial: cover property (trial_active ##1 !trial_active);
endmodule

bind fprc_top fprc_props u_props (.*);

// File: fprc_prog.sv
module fprc_prog (
   // clock
   input wire sys_clk,
   // supply pin comparator levels
   output logic high_key_pulse_level = 1'b0,
   output logic mid_address_pulse_level = 1'b0,
   output logic power_good = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   // post_blow_hold_delay in clocks, plain default
   parameter int HOLD_CYC = 16;
   // one pulse; a high key level also lifts the mid comparator
   task automatic pulse(input bit hi);
      high_key_pulse_level <= hi;
      mid_address_pulse_level <= 1'b1;
      repeat (6) @(posedge sys_clk);
      high_key_pulse_level <= 1'b0;
      mid_address_pulse_level <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   // nh highs pick the mode, nm mids pick register nm-1, a high closes
   task automatic key(input int nh, input int nm);
      repeat (nh) pulse(1'b1);
      repeat (nm) pulse(1'b0);
      pulse(1'b1);
   endtask
   // ends a session; never drops power inside the hold delay
   task automatic power_cycle;
      repeat (HOLD_CYC) @(posedge sys_clk);
      power_good <= 1'b0;
      repeat (8) @(posedge sys_clk);
      power_good <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

// File: fprc_top_tb.sv
`include "fprc_map.vh"

module fprc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err, wb = 1'b0, wi = 1'b0;
   logic hall = 1'b0, bs, step, ta, tsgn, pin_o, oe;
   logic [7:0] paddr = 8'h00, tm;
   logic [31:0] pwdata = 32'h0, prdata, rd, rnd;
   logic [13:0] fs = 14'h0, fz;
   logic [3:0] bi, lbi;
   wire hk, md, pg_ok;
   // open-drain pin with pull-up: released reads high
   wire pin_lvl = oe ? pin_o : 1'b1;
   int mismatches = 0, n_compared = 0, seed = 32'hB107, nb = 0, n0;
   int code, mg, w[3] = '{8, 1, 5}, b[3] = '{0, 8, 9};
   fprc_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .high_key_pulse_level(hk),
      .mid_address_pulse_level(md), .power_good(pg_ok), .fuse_sense(fs),
      .fuse_weak_blown(wb), .fuse_weak_intact(wi), .hall_trip(hall),
      .blow_strobe(bs), .blow_index(bi), .supply_current_step(step),
      .trial_active(ta), .trial_magnitude(tm), .trial_field_sign(tsgn),
      .sensor_output_pin_o(pin_o), .sensor_output_pin_oe(oe));
   fprc_prog pg (.sys_clk(sys_clk), .high_key_pulse_level(hk),
      .mid_address_pulse_level(md), .power_good(pg_ok));
   always #10 sys_clk = ~sys_clk;
   // blow counter, sampled mid-cycle where the strobe is settled
   always @(negedge sys_clk) begin
      if (bs === 1'b1) begin
         nb++;
         lbi = bi;
      end
   end
   // ------
   // shared tasks
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one apb transfer; idle cycle after so strobes never double up
   task automatic apb(input bit wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      if (n >= 20) begin
         mismatches++;
         results();
      end
   endtask
   // blow fuse at bit a of register r; expect image index idx
   task automatic blow(input int r, input int a, input int idx);
      n0 = nb;
      pg.key(2, r + 1);
      repeat (a) pg.pulse(1'b0);
      pg.pulse(1'b1);
      check(nb - n0, 1);
      check(lbi, idx);
      fz[idx] = 1'b1;
      pg.power_cycle();
   endtask
   // output/check register: code 8 tracks intact margin, 9 blown margin
   task automatic fuse_check;
      pg.key(1, 5);
      repeat (7) pg.pulse(1'b0);
      for (int k = 0; k < 2; k++) begin
         if (k > 0) pg.pulse(1'b0);
         for (int v = 0; v < 2; v++) begin
            wi <= v[0];
            wb <= !v[0];
            repeat (8) @(posedge sys_clk);
            check(step, v[0] ^ k[0]);
         end
      end
      wi <= 1'b0;
      wb <= 1'b0;
      pg.power_cycle();
   endtask
   // ------
   // main sequence
   // ------
   initial begin
      rnd = $random(seed);
      fz = (rnd[13:0] & 14'h17FF) | 14'h0800;
      fs = fz;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      apb(1'b0, `FPRC_CTRL_OFF, rnd);
      check(rd, 1);
      apb(1'b1, `FPRC_FUSE_OFF, rnd);
      apb(1'b0, `FPRC_FUSE_OFF, rnd);
      check(rd, fz);
      apb(1'b0, 8'h10, rnd);
      check({err, rd[30:0]}, 32'h8000_0000);
      // control readback, then pulses ignored while disabled
      rnd = $random(seed);
      apb(1'b1, `FPRC_CTRL_OFF, rnd);
      apb(1'b0, `FPRC_CTRL_OFF, rnd);
      check(rd, rnd[1:0]);
      apb(1'b1, `FPRC_CTRL_OFF, 32'h0);
      pg.key(1, 1);
      check(ta, 0);
      apb(1'b1, `FPRC_CTRL_OFF, 32'h1);
      // read back every register; random hall and margins must not show
      rnd = $random(seed);
      hall <= rnd[0];
      wb <= rnd[1];
      wi <= rnd[2];
      for (int r = 0; r < 3; r++) begin
         pg.key(3, r + 1);
         for (int i = 0; i <= w[r]; i++) begin
            if (i > 0) pg.pulse(1'b0);
            mg = b[r] + ((i < w[r]) ? i : w[r] - 1);
            check(pin_lvl, fz[mg]);
         end
         check(step, 0);
         pg.power_cycle();
      end
      wb <= 1'b0;
      wi <= 1'b0;
      // four trial registers; the first down register walks to its wrap
      for (int r = 0; r < 4; r++) begin
         rnd = $random(seed);
         hall <= rnd[0];
         pg.key(1, r + 1);
         for (int k = 0; k < 4; k++) begin
            if (k > 0) repeat ((k == 3 && r == 1) ? 253 : 1) pg.pulse(1'b0);
            code = (k == 3 && r == 1) ? 0 : k + 1;
            mg = r[0] ? 255 - code : code;
            check(tm, mg);
            check(tsgn, r[1]);
            check(ta, 1);
            check(oe, !(hall ^ fz[11]));
         end
         apb(1'b0, `FPRC_TRIM_OFF, rnd);
         check(rd, code + (mg << 8) + (r[1] << 16) + 32'h2_0000);
         pg.power_cycle();
         check(ta, 0);
      end
      fuse_check();
      // polarity first, a magnitude bit, lock last
      blow(2, 2, 11);
      blow(0, 3, 3);
      blow(2, 4, 13);
      fs <= fz;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      apb(1'b0, `FPRC_FUSE_OFF, rnd);
      check(rd, fz);
      pg.key(3, 1);
      apb(1'b0, `FPRC_STAT_OFF, rnd);
      check(rd[11], 1);
      pg.power_cycle();
      n0 = nb;
      pg.key(2, 1);
      pg.pulse(1'b1);
      check(nb - n0, 0);
      pg.power_cycle();
      pg.key(1, 1);
      check(ta, 0);
      pg.power_cycle();
      fuse_check();
      results();
   end
endmodule
